// ==== shared/dcc_pkg.sv ====
// Shared constants and types for the DMA channel controller
package dcc_pkg;
  // ==========================================================
  // Sizes
  localparam int CHANNELS = 32;
  localparam int STRUCTS = 64;
  // ==========================================================
  // Register map, byte addresses on the slave port
  localparam logic [11:0] ENABLE_SET_OFS = 12'h000;
  localparam logic [11:0] ENABLE_CLR_OFS = 12'h004;
  localparam logic [11:0] ENABLE_STAT_OFS = 12'h008;
  localparam logic [11:0] ATTR_BASE_OFS = 12'h010;
  localparam logic [11:0] ATTR_END_OFS = 12'h030;
  localparam logic [1:0] TABLE_SEL = 2'h1;
  localparam logic [1:0] WORD_SRC = 2'h0;
  localparam logic [1:0] WORD_DST = 2'h1;
  localparam logic [1:0] WORD_CTRL = 2'h2;
  // ==========================================================
  // Reset values
  localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;
  localparam logic [31:0] ATTR_RESET = 32'h0000_0000;
  localparam logic [31:0] TABLE_RESET = 32'h0000_0000;
  // ==========================================================
  // Control word fields
  localparam int MODE_LSB = 0;
  localparam int MODE_W = 3;
  localparam int TAIL_BIT = 3;
  localparam int COUNT_LSB = 4;
  localparam int COUNT_W = 11;
  localparam int ARB_LSB = 15;
  localparam int ARB_W = 4;
  localparam int SIZE_LSB = 19;
  localparam int SRC_INC_LSB = 21;
  localparam int DST_INC_LSB = 23;
  // ==========================================================
  // Modes
  localparam logic [2:0] mode_stopped = 3'h0;
  localparam logic [2:0] mode_basic_request = 3'h1;
  localparam logic [2:0] mode_auto_complete = 3'h2;
  localparam logic [2:0] mode_double_buffer = 3'h3;
  localparam logic [2:0] mode_memory_task_list = 3'h4;
  localparam logic [2:0] mode_peripheral_task_list = 3'h6;
  // ==========================================================
  // Item sizes, increments, arbitration
  localparam logic [1:0] item_size_byte = 2'h0;
  localparam logic [1:0] item_size_halfword = 2'h1;
  localparam logic [1:0] item_size_word = 2'h2;
  localparam logic [1:0] inc_byte = 2'h0;
  localparam logic [1:0] inc_halfword = 2'h1;
  localparam logic [1:0] inc_word = 2'h2;
  localparam logic [1:0] source_fixed = 2'h3;
  localparam logic [1:0] destination_fixed = 2'h3;
  localparam logic [3:0] rearbitrate_max = 4'ha;
  // ==========================================================
  // Attributes, structure select and task list steps
  localparam int burst_only_attr = 0;
  localparam int use_alternate_struct_attr = 1;
  localparam int high_priority_attr = 2;
  localparam int request_mask_attr = 3;
  localparam logic primary_struct_select = 1'b0;
  localparam logic alternate_struct_select = 1'b1;
  localparam logic [31:0] TASK_STRIDE = 32'h0000_0010;
  localparam logic [31:0] WORD_STEP = 32'h0000_0004;
  localparam logic [1:0] TASK_LAST_WORD = 2'h2;

  typedef enum logic [2:0] {
    st_idle, st_load, st_task, st_tupd, st_read, st_write, st_save, st_finish
  } dcc_state_e;
endpackage : dcc_pkg

// ==== src/dcc_dma_ctrl.sv ====
// DMA channel controller: 32 channels, control table, slave and memory master ports
// ==========================================================
module dcc_dma_ctrl (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [31:0] mem_address,
  output logic mem_read,
  output logic mem_write,
  output logic [31:0] mem_writedata,
  output logic [3:0] mem_byteenable,
  input wire logic [31:0] mem_readdata,
  input wire logic mem_waitrequest,
  input wire logic [31:0] req_single,
  input wire logic [31:0] req_burst,
  output logic [31:0] xfer_done
);
  // ==========================================================
  // Functions
  function automatic logic [31:0] inc_amt(input logic [1:0] code);
    unique case (code)
      dcc_pkg::inc_byte: inc_amt = 32'h0000_0001;
      dcc_pkg::inc_halfword: inc_amt = 32'h0000_0002;
      dcc_pkg::inc_word: inc_amt = 32'h0000_0004;
      default: inc_amt = 32'h0000_0000;
    endcase
  endfunction : inc_amt

  function automatic logic [3:0] be_of(input logic [1:0] size, input logic [1:0] a);
    unique case (size)
      dcc_pkg::item_size_byte: be_of = 4'h1 << a;
      dcc_pkg::item_size_halfword: be_of = 4'h3 << {a[1], 1'b0};
      default: be_of = 4'hf;
    endcase
  endfunction : be_of

  function automatic logic [4:0] first_set(input logic [31:0] v);
    first_set = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        first_set = 5'(i);
      end
    end
  endfunction : first_set

  function automatic logic [2:0] mode_of(input logic [31:0] c);
    mode_of = c[dcc_pkg::MODE_LSB +: dcc_pkg::MODE_W];
  endfunction : mode_of

  function automatic logic is_sg(input logic [2:0] m);
    is_sg = (m == dcc_pkg::mode_memory_task_list) || (m == dcc_pkg::mode_peripheral_task_list);
  endfunction : is_sg

  function automatic logic [10:0] count_of(input logic [31:0] c);
    count_of = c[dcc_pkg::COUNT_LSB +: dcc_pkg::COUNT_W];
  endfunction : count_of

  // ==========================================================
  // State
  dcc_pkg::dcc_state_e st_r;
  logic [4:0] ch_r;
  logic alt_r;
  logic [1:0] tw_r;
  logic [10:0] beat_r;
  logic [31:0] cur_src_r, cur_dst_r, cur_ctrl_r;
  logic [31:0] enable_r, auto_act_r, tail_only_r;
  logic [3:0][31:0] attr_r;
  logic [31:0] single_s1_r, single_s2_r, burst_s1_r, burst_s2_r;
  logic [31:0] src_mem [dcc_pkg::STRUCTS];
  logic [31:0] dst_mem [dcc_pkg::STRUCTS];
  logic [31:0] ctl_mem [dcc_pkg::STRUCTS];
  logic [31:0] avs_readdata_r, mem_address_r, mem_writedata_r, xfer_done_r;
  logic avs_waitrequest_r, mem_read_r, mem_write_r;
  logic [3:0] mem_byteenable_r;

  // ==========================================================
  // Slave decode
  wire bus_busy_w;
  wire bus_take = (avs_read | avs_write) & avs_waitrequest_r & ~bus_busy_w;
  wire bus_wr = bus_take & avs_write;
  wire attr_hit = (avs_address >= dcc_pkg::ATTR_BASE_OFS) && (avs_address < dcc_pkg::ATTR_END_OFS);
  wire [11:0] attr_off = avs_address - dcc_pkg::ATTR_BASE_OFS;
  wire [1:0] attr_sel = attr_off[4:3];
  wire attr_clr_op = attr_off[2];
  wire tbl_hit = (avs_address[11:10] == dcc_pkg::TABLE_SEL);
  wire [5:0] tbl_idx = avs_address[9:4];
  wire [1:0] tbl_word = avs_address[3:2];
  wire tbl_wr = bus_wr & tbl_hit;
  wire [31:0] sw_en_set = (bus_wr && avs_address == dcc_pkg::ENABLE_SET_OFS) ? avs_writedata : 32'h0;
  wire [31:0] sw_en_clr = (bus_wr && avs_address == dcc_pkg::ENABLE_CLR_OFS) ? avs_writedata : 32'h0;
  wire enable_hit = (avs_address == dcc_pkg::ENABLE_SET_OFS) || (avs_address == dcc_pkg::ENABLE_CLR_OFS)
                    || (avs_address == dcc_pkg::ENABLE_STAT_OFS);
  wire [31:0] tbl_rd = (tbl_word == dcc_pkg::WORD_SRC) ? src_mem[tbl_idx] :
                       (tbl_word == dcc_pkg::WORD_DST) ? dst_mem[tbl_idx] :
                       (tbl_word == dcc_pkg::WORD_CTRL) ? ctl_mem[tbl_idx] : 32'h0;
  wire [31:0] rd_val = enable_hit ? enable_r :
                       attr_hit ? attr_r[attr_sel] :
                       tbl_hit ? tbl_rd : 32'h0;

  // ==========================================================
  // Arbitration
  wire [31:0] burst_ok = attr_r[dcc_pkg::burst_only_attr] | tail_only_r;
  wire [31:0] hw_req = (burst_s2_r | (single_s2_r & ~burst_ok)) & ~attr_r[dcc_pkg::request_mask_attr];
  wire [31:0] elig = enable_r & (hw_req | auto_act_r);
  wire [31:0] elig_hi = elig & attr_r[dcc_pkg::high_priority_attr];
  wire [4:0] grant = first_set((|elig_hi) ? elig_hi : elig);

  // ==========================================================
  // Current structure decode
  wire [5:0] cur_idx = {alt_r, ch_r};
  wire [31:0] t_ctrl = ctl_mem[cur_idx];
  wire [2:0] t_mode = mode_of(t_ctrl);
  wire [2:0] c_mode = mode_of(cur_ctrl_r);
  wire [10:0] c_cnt = count_of(cur_ctrl_r);
  wire [10:0] cnt_dec = c_cnt - 11'h001;
  wire [3:0] c_arb = cur_ctrl_r[dcc_pkg::ARB_LSB +: dcc_pkg::ARB_W];
  wire [1:0] c_size = cur_ctrl_r[dcc_pkg::SIZE_LSB +: 2];
  wire [31:0] nsrc = cur_src_r + inc_amt(cur_ctrl_r[dcc_pkg::SRC_INC_LSB +: 2]);
  wire [31:0] ndst = cur_dst_r + inc_amt(cur_ctrl_r[dcc_pkg::DST_INC_LSB +: 2]);
  wire [10:0] arb_items = 11'h001 << ((c_arb > dcc_pkg::rearbitrate_max) ? dcc_pkg::rearbitrate_max : c_arb);
  wire [10:0] beat_inc = beat_r + 11'h001;
  wire chunk_end = (beat_inc == arb_items);
  wire last_item = (c_cnt == 11'h001);
  wire [31:0] prim_ctrl = ctl_mem[{dcc_pkg::primary_struct_select, ch_r}];
  wire [2:0] oth_mode = mode_of(ctl_mem[{~alt_r, ch_r}]);
  wire [31:0] ch_onehot = 32'h0000_0001 << ch_r;
  wire [31:0] rd_item = mem_readdata >> {cur_src_r[1:0], 3'b000};
  wire [31:0] wr_data = (c_size == dcc_pkg::item_size_byte) ? {4{rd_item[7:0]}} :
                        (c_size == dcc_pkg::item_size_halfword) ? {2{rd_item[15:0]}} : rd_item;

  wire in_load = (st_r == dcc_pkg::st_load);
  wire in_fin = (st_r == dcc_pkg::st_finish);
  wire in_tupd = (st_r == dcc_pkg::st_tupd);
  wire task_acc = (st_r == dcc_pkg::st_task) & mem_read_r & ~mem_waitrequest;
  wire rd_acc = (st_r == dcc_pkg::st_read) & mem_read_r & ~mem_waitrequest;
  wire wr_acc = (st_r == dcc_pkg::st_write) & mem_write_r & ~mem_waitrequest;
  wire load_stop = in_load && (t_mode == dcc_pkg::mode_stopped);
  wire load_empty = in_load && is_sg(t_mode) && !alt_r && (count_of(t_ctrl) == 11'h000);
  wire fin_pp = (c_mode == dcc_pkg::mode_double_buffer);
  wire fin_sg = alt_r && is_sg(mode_of(prim_ctrl));
  wire fin_done = fin_pp ? (oth_mode == dcc_pkg::mode_stopped) :
                  fin_sg ? (count_of(prim_ctrl) == 11'h000) : 1'b1;
  wire complete = (in_fin && fin_done) || load_empty;
  wire [31:0] dis_vec = (complete || load_stop) ? ch_onehot : 32'h0;
  wire [31:0] alt_set_vec = (in_tupd || (in_fin && fin_pp && !alt_r)) ? ch_onehot : 32'h0;
  wire [31:0] alt_clr_vec = (in_fin && ((fin_pp && alt_r) || (!fin_pp && fin_sg))) ? ch_onehot : 32'h0;
  wire keep_auto = fin_sg && (mode_of(prim_ctrl) == dcc_pkg::mode_memory_task_list);
  wire [31:0] auto_set = (in_load && (t_mode == dcc_pkg::mode_auto_complete
                          || t_mode == dcc_pkg::mode_memory_task_list)) ? ch_onehot : 32'h0;
  wire [31:0] auto_clr = ((in_fin && !keep_auto) ? ch_onehot : 32'h0) | dis_vec;
  wire [31:0] tail_set = (in_tupd && last_item && cur_ctrl_r[dcc_pkg::TAIL_BIT]) ? ch_onehot : 32'h0;

  // ==========================================================
  // Engine writes into the table
  wire [2:0] e_we = (in_fin || in_tupd || st_r == dcc_pkg::st_save) ? 3'h7 : task_acc ? (3'h1 << tw_r) : 3'h0;
  wire [5:0] e_idx = task_acc ? {dcc_pkg::alternate_struct_select, ch_r} : cur_idx;
  wire [31:0] e_src = task_acc ? mem_readdata : in_tupd ? cur_src_r + dcc_pkg::TASK_STRIDE : cur_src_r;
  wire [31:0] e_dst = task_acc ? mem_readdata : cur_dst_r;
  wire [31:0] ctrl_cnt = {cur_ctrl_r[31:dcc_pkg::ARB_LSB], cnt_dec, cur_ctrl_r[dcc_pkg::COUNT_LSB-1:0]};
  wire [31:0] ctrl_stop = {cur_ctrl_r[31:dcc_pkg::MODE_W], dcc_pkg::mode_stopped};
  wire [31:0] e_ctrl = task_acc ? mem_readdata : in_fin ? ctrl_stop : in_tupd ? ctrl_cnt : cur_ctrl_r;
  assign bus_busy_w = |e_we;

  // ==========================================================
  // Slave handshake: one wait cycle, more while the engine writes the table, then answer
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_waitrequest_r <= 1'b1;
      avs_readdata_r <= 32'h0;
    end else begin
      avs_waitrequest_r <= ~bus_take;
      avs_readdata_r <= bus_take ? rd_val : avs_readdata_r;
    end
  end

  // ==========================================================
  // Request synchronisers, pins are asynchronous
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      single_s1_r <= 32'h0;
      single_s2_r <= 32'h0;
      burst_s1_r <= 32'h0;
      burst_s2_r <= 32'h0;
    end else begin
      single_s1_r <= req_single;
      single_s2_r <= single_s1_r;
      burst_s1_r <= req_burst;
      burst_s2_r <= burst_s1_r;
    end
  end

  // ==========================================================
  // Enables and per-channel flags; a software set beats a hardware clear
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      enable_r <= dcc_pkg::ENABLE_RESET;
      auto_act_r <= 32'h0;
      tail_only_r <= 32'h0;
      xfer_done_r <= 32'h0;
    end else begin
      enable_r <= ((enable_r & ~dis_vec) & ~sw_en_clr) | sw_en_set;
      auto_act_r <= (auto_act_r | auto_set) & ~auto_clr;
      tail_only_r <= (tail_only_r | tail_set) & ~dis_vec;
      xfer_done_r <= complete ? ch_onehot : 32'h0;
    end
  end

  // ==========================================================
  // Attributes
  for (genvar a = 0; a < 4; a++) begin : g_attr
    wire [31:0] sw_set = (bus_wr && attr_hit && attr_sel == 2'(a) && !attr_clr_op) ? avs_writedata : 32'h0;
    wire [31:0] sw_clr = (bus_wr && attr_hit && attr_sel == 2'(a) && attr_clr_op) ? avs_writedata : 32'h0;
    wire [31:0] hw_set = (a == dcc_pkg::use_alternate_struct_attr) ? alt_set_vec : 32'h0;
    wire [31:0] hw_clr = (a == dcc_pkg::use_alternate_struct_attr) ? alt_clr_vec : 32'h0;
    always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
        attr_r[a] <= dcc_pkg::ATTR_RESET;
      end else begin
        attr_r[a] <= (((attr_r[a] | hw_set) & ~hw_clr) & ~sw_clr) | sw_set;
      end
    end
  end

  // ==========================================================
  // Control table; the engine has the port first, the bus waits
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < dcc_pkg::STRUCTS; i++) begin
        src_mem[i] <= dcc_pkg::TABLE_RESET;
        dst_mem[i] <= dcc_pkg::TABLE_RESET;
        ctl_mem[i] <= dcc_pkg::TABLE_RESET;
      end
    end else if (|e_we) begin
      if (e_we[0]) src_mem[e_idx] <= e_src;
      if (e_we[1]) dst_mem[e_idx] <= e_dst;
      if (e_we[2]) ctl_mem[e_idx] <= e_ctrl;
    end else if (tbl_wr) begin
      if (tbl_word == dcc_pkg::WORD_SRC) src_mem[tbl_idx] <= avs_writedata;
      if (tbl_word == dcc_pkg::WORD_DST) dst_mem[tbl_idx] <= avs_writedata;
      if (tbl_word == dcc_pkg::WORD_CTRL) ctl_mem[tbl_idx] <= avs_writedata;
    end
  end

  // ==========================================================
  // Transfer engine
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= dcc_pkg::st_idle;
      ch_r <= 5'h00;
      alt_r <= 1'b0;
      tw_r <= 2'h0;
      beat_r <= 11'h000;
      cur_src_r <= 32'h0;
      cur_dst_r <= 32'h0;
      cur_ctrl_r <= 32'h0;
      mem_read_r <= 1'b0;
      mem_write_r <= 1'b0;
      mem_address_r <= 32'h0;
      mem_writedata_r <= 32'h0;
      mem_byteenable_r <= 4'hf;
    end else begin
      unique case (st_r)
        dcc_pkg::st_idle: begin
          if (|elig) begin
            ch_r <= grant;
            alt_r <= attr_r[dcc_pkg::use_alternate_struct_attr][grant];
            st_r <= dcc_pkg::st_load;
          end
        end
        dcc_pkg::st_load: begin
          cur_src_r <= src_mem[cur_idx];
          cur_dst_r <= dst_mem[cur_idx];
          cur_ctrl_r <= t_ctrl;
          beat_r <= 11'h000;
          tw_r <= 2'h0;
          if (load_stop || load_empty) begin
            st_r <= dcc_pkg::st_idle;
          end else begin
            st_r <= (is_sg(t_mode) && !alt_r) ? dcc_pkg::st_task : dcc_pkg::st_read;
            mem_read_r <= 1'b1;
            mem_byteenable_r <= 4'hf;
            mem_address_r <= {src_mem[cur_idx][31:2], 2'b00};
          end
        end
        dcc_pkg::st_task: begin
          if (task_acc) begin
            if (tw_r == dcc_pkg::TASK_LAST_WORD) begin
              mem_read_r <= 1'b0;
              st_r <= dcc_pkg::st_tupd;
            end else begin
              tw_r <= tw_r + 2'h1;
              mem_address_r <= mem_address_r + dcc_pkg::WORD_STEP;
            end
          end
        end
        dcc_pkg::st_tupd: begin
          alt_r <= dcc_pkg::alternate_struct_select;
          st_r <= dcc_pkg::st_load;
        end
        dcc_pkg::st_read: begin
          if (rd_acc) begin
            mem_read_r <= 1'b0;
            mem_write_r <= 1'b1;
            mem_address_r <= {cur_dst_r[31:2], 2'b00};
            mem_writedata_r <= wr_data;
            mem_byteenable_r <= be_of(c_size, cur_dst_r[1:0]);
            st_r <= dcc_pkg::st_write;
          end
        end
        dcc_pkg::st_write: begin
          if (wr_acc) begin
            mem_write_r <= 1'b0;
            cur_src_r <= nsrc;
            cur_dst_r <= ndst;
            cur_ctrl_r <= ctrl_cnt;
            beat_r <= beat_inc;
            if (last_item) begin
              st_r <= dcc_pkg::st_finish;
            end else if (chunk_end) begin
              st_r <= dcc_pkg::st_save;
            end else begin
              mem_read_r <= 1'b1;
              mem_byteenable_r <= 4'hf;
              mem_address_r <= {nsrc[31:2], 2'b00};
              st_r <= dcc_pkg::st_read;
            end
          end
        end
        dcc_pkg::st_save: st_r <= dcc_pkg::st_idle;
        dcc_pkg::st_finish: st_r <= dcc_pkg::st_idle;
      endcase
    end
  end

  // ==========================================================
  // Outputs
  assign avs_readdata = avs_readdata_r;
  assign avs_waitrequest = avs_waitrequest_r;
  assign mem_address = mem_address_r;
  assign mem_read = mem_read_r;
  assign mem_write = mem_write_r;
  assign mem_writedata = mem_writedata_r;
  assign mem_byteenable = mem_byteenable_r;
  assign xfer_done = xfer_done_r;
endmodule : dcc_dma_ctrl

// ==== tb/dcc_dma_ctrl_asserts.sv ====
// Port checker for the DMA channel controller
module dcc_dma_ctrl_asserts (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [31:0] mem_address,
  input wire logic mem_read,
  input wire logic mem_write,
  input wire logic [31:0] mem_writedata,
  input wire logic [3:0] mem_byteenable,
  input wire logic mem_waitrequest,
  input wire logic [31:0] xfer_done
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // ==========================================================
  // Stalled memory requests, slave acks, read lanes and done pulses
  sequence s_rd_stall; mem_read && mem_waitrequest; endsequence
  sequence s_wr_stall; mem_write && mem_waitrequest; endsequence
  a_ack_one: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("ack held");
  a_ack_cause: assert property (!avs_waitrequest |-> $past(avs_read || avs_write)) else $error("stray ack");
  a_rd_hold: assert property (s_rd_stall |=> mem_read && $stable(mem_address)) else $error("read dropped");
  a_wr_hold: assert property (s_wr_stall |=> mem_write && $stable(mem_writedata)) else $error("write dropped");
  a_rd_wr_excl: assert property (!(mem_read && mem_write)) else $error("read and write");
  a_rd_lanes: assert property (mem_read |-> mem_byteenable == 4'hf) else $error("read lanes");
  a_done_pulse: assert property (|xfer_done |=> (xfer_done & $past(xfer_done)) == 32'h0) else $error("long done");
  a_done_cause: assert property (|xfer_done |-> $past(mem_write && !mem_waitrequest, 2)) else $error("early done");
endmodule : dcc_dma_ctrl_asserts
bind dcc_dma_ctrl dcc_dma_ctrl_asserts chk (.sys_clk, .reset_n, .avs_read, .avs_write, .avs_waitrequest,
  .mem_address, .mem_read, .mem_write, .mem_writedata, .mem_byteenable, .mem_waitrequest, .xfer_done);

// ==== tb/dcc_dma_ctrl_tb_top.sv ====
// Self-checking testbench for the DMA channel controller
module dcc_dma_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [11:0] avs_address = 12'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic slow = 1'b0;
  logic polling = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] req_single = 32'h0;
  logic [31:0] req_burst = 32'h0;
  logic [31:0] avs_readdata, mem_address, mem_writedata, mem_readdata, xfer_done, rdata, c;
  logic [3:0] mem_byteenable;
  logic avs_waitrequest, mem_read, mem_write, mem_waitrequest;
  logic [31:0] exp_q[$];
  logic [31:0] done_q[$];
  int num_errors = 0;
  int compares = 0;
  dcc_dma_ctrl uut (.sys_clk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .mem_address, .mem_read, .mem_write, .mem_writedata, .mem_byteenable, .mem_readdata,
    .mem_waitrequest, .req_single, .req_burst, .xfer_done);
  dcc_mem_model mem_i (.sys_clk, .slow, .mem_address, .mem_read, .mem_write, .mem_writedata,
    .mem_byteenable, .mem_readdata, .mem_waitrequest);
  initial forever #50 sys_clk = ~sys_clk;
  // ==========================================================
  // Bus tasks and checks
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask : check
  task automatic wrap_up;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    // Request stands until the edge that samples waitrequest low
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    rdata = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      num_errors++;
      wrap_up();
    end
    // One idle edge so the strobe is never driven twice in a time step
    @(posedge sys_clk);
  endtask : bus
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd
  task automatic wait_off(input int ch);
    polling = 1'b1;
    repeat (200) begin
      bus(1'b0, 12'h008, 32'h0);
      if (rdata[ch] === 1'b0) break;
    end
    polling = 1'b0;
    rd(12'h008, 32'h0);
  endtask : wait_off
  task automatic setup(input int ch, input int alt, input logic [31:0] s, input logic [31:0] d);
    logic [11:0] b;
    b = 12'h400 + 12'((ch + 32 * alt) * 16);
    bus(1'b1, b, s);
    bus(1'b1, b + 12'h4, d);
    bus(1'b1, b + 12'h8, c);
    rd(b + 12'h8, c);
    bus(1'b1, 12'h000, 32'h1 << ch);
  endtask : setup
  function automatic logic [31:0] ctl(input logic [2:0] m, input logic [10:0] n, input logic [5:0] f);
    return {7'h0, f[1:0], f[3:2], f[5:4], 4'h0, n, 1'b0, m};
  endfunction : ctl
  always @(negedge sys_clk) begin
    if (avs_read && avs_waitrequest === 1'b0 && !polling && exp_q.size() > 0) check(avs_readdata, exp_q.pop_front());
    if (xfer_done !== 32'h0) check(xfer_done, done_q.size() > 0 ? done_q.pop_front() : 32'h0);
  end
  initial begin
    repeat (30000) @(posedge sys_clk);
    num_errors++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'h198b));
    for (int i = 0; i < 256; i++) mem_i.mem[i] = (i < 64) ? $urandom() : 32'h0;
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    rd(12'h0fc, 32'h0);
    repeat (3) rd(12'h5f8, 32'h0);
    for (int m = 0; m < 7; m++) begin
      bus(1'b1, 12'h5f8, 32'(m));
      rd(12'h5f8, 32'(m));
      bus(1'b1, 12'h010 + 12'(8 * (m % 4)), 32'h8000_0000);
      rd(12'h014 + 12'(8 * (m % 4)), 32'h8000_0000);
      bus(1'b1, 12'h014 + 12'(8 * (m % 4)), 32'h8000_0000);
      rd(12'h010 + 12'(8 * (m % 4)), 32'h0);
    end
    $display("test registers done");
    c = ctl(3'h1, 11'h4, 6'h2a);
    setup(2, 0, 32'h0, 32'h100);
    done_q.push_back(32'h4);
    req_burst[2] <= 1'b1;
    wait_off(2);
    req_burst[2] <= 1'b0;
    rd(12'h428, c & ~32'h7ff7);
    for (int i = 0; i < 4; i++) check(mem_i.mem[64 + i], mem_i.mem[i]);
    $display("test word copy done");
    slow <= 1'b1;
    bus(1'b1, 12'h018, 32'h40);
    c = ctl(3'h2, 11'h3, 6'h03);
    setup(6, 1, 32'h4, 32'h180);
    done_q.push_back(32'h40);
    req_single[6] <= 1'b1;
    repeat (5) @(posedge sys_clk);
    req_single[6] <= 1'b0;
    wait_off(6);
    rd(12'h668, c & ~32'h7ff7);
    check(mem_i.mem[96], {24'h0, mem_i.mem[1][23:16]});
    $display("test byte alternate done");
    bus(1'b1, 12'h010, 32'h200);
    c = ctl(3'h1, 11'h1, 6'h2a);
    setup(9, 0, 32'h8, 32'h200);
    req_single[9] <= 1'b1;
    repeat (20) @(posedge sys_clk);
    rd(12'h008, 32'h200);
    bus(1'b1, 12'h028, 32'h200);
    req_burst[9] <= 1'b1;
    repeat (20) @(posedge sys_clk);
    rd(12'h008, 32'h200);
    bus(1'b1, 12'h004, 32'h200);
    bus(1'b1, 12'h02c, 32'h200);
    repeat (20) @(posedge sys_clk);
    check(mem_i.mem[128], 32'h0);
    done_q.push_back(32'h200);
    bus(1'b1, 12'h000, 32'h200);
    wait_off(9);
    check(mem_i.mem[128], mem_i.mem[2]);
    $display("test gating done");
    mem_i.mem[160] = 32'h10;
    mem_i.mem[161] = 32'h2c0;
    mem_i.mem[162] = ctl(3'h2, 11'h2, 6'h2a);
    c = ctl(3'h4, 11'h1, 6'h2a);
    setup(12, 0, 32'h280, 32'h0);
    done_q.push_back(32'h1000);
    req_single[12] <= 1'b1;
    repeat (5) @(posedge sys_clk);
    req_single[12] <= 1'b0;
    wait_off(12);
    rd(12'h4c8, c & ~32'h7ff0);
    rd(12'h6c8, mem_i.mem[162] & ~32'h7ff7);
    rd(12'h018, 32'h40);
    for (int i = 0; i < 2; i++) check(mem_i.mem[176 + i], mem_i.mem[4 + i]);
    $display("test task list done");
    wrap_up();
  end
endmodule : dcc_dma_ctrl_tb_top

// ==== tb/dcc_mem_model.sv ====
// Memory partner model with optional random stalls
module dcc_mem_model (
  input wire logic sys_clk,
  input wire logic slow,
  input wire logic [31:0] mem_address,
  input wire logic mem_read,
  input wire logic mem_write,
  input wire logic [31:0] mem_writedata,
  input wire logic [3:0] mem_byteenable,
  output logic [31:0] mem_readdata,
  output logic mem_waitrequest
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [256];
  logic [31:0] junk_r = 32'h5a5a_a5a5;
  wire logic [7:0] idx = mem_address[9:2];
  // Released bus shows a moving pattern, never stale data
  assign mem_readdata = (mem_read && !mem_waitrequest) ? mem[idx] : junk_r;
  initial mem_waitrequest = 1'b1;
  always @(posedge sys_clk) begin
    junk_r <= ~junk_r;
    mem_waitrequest <= slow ? 1'($urandom % 2) : 1'b0;
    if (mem_write && !mem_waitrequest) begin
      for (int b = 0; b < 4; b++) if (mem_byteenable[b]) mem[idx][8*b +: 8] <= mem_writedata[8*b +: 8];
    end
  end
endmodule : dcc_mem_model
